/* File: hw/fao_defines.svh */
// Constants for the flow alarm output logic: offsets, fields, resets, timing.
// How it works
// R1 - Latch choice: none, high or low
// R2 - Unlatched alarm sets at threshold, hysteresis clears
// R3 - High latch sets when flow above threshold
// R4 - Low latch sets when flow below threshold
// R5 - Hysteresis used only when latching is none
// R6 - Latched alarm holds, latch indication shown
// R7 - Reset pin or 3 s button clears latch
// R8 - Alarms compare against filtered displayed flow
// R9 - Invert swaps output in every mode except off, where the output stays low
// R10 - Dual mode: on outside lower/upper range
// R11 - Dual mode hysteresis or latch like single
// R12 - Reverse mode follows flow sign, never latches
// R13 - Threshold is user flow value for switching
// R14 - Band is percent of threshold
// R15 - Reset level synchronised, ignored when unlatched
`ifndef FAO_DEFINES_SVH
`define FAO_DEFINES_SVH

// ==========================================================================
// Register offsets (byte addresses)
// ==========================================================================
`define FAO_ADDR_CTRL 8'h00
`define FAO_ADDR_THR 8'h04
`define FAO_ADDR_UPPER 8'h08
`define FAO_ADDR_HYST 8'h0C
`define FAO_ADDR_STAT 8'h10
`define FAO_ADDR_IRQ_ST 8'h14
`define FAO_ADDR_IRQ_MASK 8'h18
`define FAO_ADDR_W 8

// ==========================================================================
// Control register fields
// ==========================================================================
`define FAO_CTRL_MODE_LSB 0
`define FAO_CTRL_MODE_MSB 1
`define FAO_CTRL_LATCH_LSB 2
`define FAO_CTRL_LATCH_MSB 3
`define FAO_CTRL_INVERT 4
`define FAO_CTRL_RST 32'h0000_0000

// ==========================================================================
// Status fields and interrupt bits
// ==========================================================================
`define FAO_STAT_ALARM 0
`define FAO_STAT_LATCHED 1
`define FAO_STAT_OUT 2
`define FAO_IRQ_SET 0
`define FAO_IRQ_LATCH 1
`define FAO_IRQ_CLEAR 2
`define FAO_IRQ_W 3

// ==========================================================================
// Reset values and sizes
// ==========================================================================
`define FAO_THR_RST 32'h0000_0000
`define FAO_HYST_RST 8'h00
`define FAO_HYST_W 8
`define FAO_PCT_DIV 100
`define FAO_RESP_OKAY 2'h0
`define FAO_RESP_SLVERR 2'h2

// ==========================================================================
// Timing
// ==========================================================================
`define FAO_CLK_HZ 125000000
`define FAO_HOLD_S 3
`define FAO_HOLD_CYC (`FAO_HOLD_S * `FAO_CLK_HZ)

`endif

/* File: hw/fao_pkg.sv */
// Types shared by the flow alarm output logic.
package fao_pkg;

  typedef enum logic [1:0] {
    FAO_MODE_OFF,
    FAO_MODE_SINGLE,
    FAO_MODE_DUAL,
    FAO_MODE_REVERSE
  } fao_mode_t;

  typedef enum logic [1:0] {
    FAO_LATCH_NONE,
    FAO_LATCH_HIGH,
    FAO_LATCH_LOW,
    FAO_LATCH_RSVD
  } fao_latch_t;

endpackage

/* File: hw/fao_alarm.sv */
// Flow alarm output logic with its AXI4-Lite register slave.
`include "fao_defines.svh"

module fao_alarm #(
  parameter logic [31:0] HOLD_CYC = `FAO_HOLD_CYC
) (
  input wire logic i_clk, // 125 MHz clock
  input wire logic i_rst, // async reset, high
  input wire logic signed [31:0] i_flow, // filtered displayed flow
  input wire logic i_flow_valid, // new flow sample strobe
  input wire logic i_reset_pin, // remote latch reset level
  input wire logic i_button, // left button, high while held
  output logic o_alarm, // alarm output pin level
  output logic o_latch_ind, // display latch indication
  output logic o_irq, // level interrupt
  input wire logic [7:0] i_awaddr, // write address
  input wire logic i_awvalid, // write address valid
  output logic o_awready, // write address ready
  input wire logic [31:0] i_wdata, // write data
  input wire logic [3:0] i_wstrb, // write strobes
  input wire logic i_wvalid, // write data valid
  output logic o_wready, // write data ready
  output logic [1:0] o_bresp, // write response
  output logic o_bvalid, // write response valid
  input wire logic i_bready, // write response ready
  input wire logic [7:0] i_araddr, // read address
  input wire logic i_arvalid, // read address valid
  output logic o_arready, // read address ready
  output logic [31:0] o_rdata, // read data
  output logic [1:0] o_rresp, // read response
  output logic o_rvalid, // read data valid
  input wire logic i_rready // read data ready
);

  // ========================================================================
  // Register state
  // ========================================================================
  logic [31:0] ctrl_q, ctrl_d;
  logic signed [31:0] thr_q, thr_d;
  logic signed [31:0] upper_q, upper_d;
  logic [`FAO_HYST_W-1:0] hyst_q, hyst_d;
  logic [`FAO_IRQ_W-1:0] ist_q, ist_d;
  logic [`FAO_IRQ_W-1:0] imask_q, imask_d;
  logic aw_hold_q, aw_hold_d;
  logic w_hold_q, w_hold_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic do_write;

  // ========================================================================
  // Alarm state
  // ========================================================================
  logic alarm_q, alarm_d;
  logic latched_q, latched_d;
  logic out_q, out_d;
  logic rpin_s1_q, rpin_s2_q;
  logic [31:0] hold_cnt_q, hold_cnt_d;
  logic btn_fired_q, btn_fired_d;

  fao_pkg::fao_mode_t mode;
  fao_pkg::fao_latch_t latch_sel;
  logic invert;
  logic signed [31:0] thr_abs;
  logic signed [31:0] band;
  logic signed [31:0] up_abs;
  logic signed [31:0] band_up;
  logic [39:0] prod_lo;
  logic [39:0] prod_up;
  logic above, over, below, outside, back_lo, back_in;
  logic clear_req;

  assign mode = fao_pkg::fao_mode_t'(
    ctrl_q[`FAO_CTRL_MODE_MSB:`FAO_CTRL_MODE_LSB]);
  assign latch_sel = fao_pkg::fao_latch_t'(
    ctrl_q[`FAO_CTRL_LATCH_MSB:`FAO_CTRL_LATCH_LSB]);
  assign invert = ctrl_q[`FAO_CTRL_INVERT];

  // ========================================================================
  // Flow comparisons
  // ========================================================================
  // The band is a percent of each bound magnitude, so it never goes negative.
  always_comb begin
    thr_abs = thr_q[31] ? -thr_q : thr_q;
    up_abs = upper_q[31] ? -upper_q : upper_q;
    prod_lo = 40'(thr_abs) * 40'(hyst_q);
    prod_up = 40'(up_abs) * 40'(hyst_q);
    band = 32'(prod_lo / 40'(`FAO_PCT_DIV)); // see R14
    band_up = 32'(prod_up / 40'(`FAO_PCT_DIV)); // see R14
    above = i_flow >= thr_q; // see R13 see R8
    below = i_flow < thr_q; // see R4
    outside = (i_flow < thr_q) || (i_flow > upper_q); // see R10
    back_lo = i_flow < (thr_q - band); // see R2
    over = i_flow > thr_q; // see R3
    back_in = (i_flow >= (thr_q + band)) &&
              (i_flow <= (upper_q - band_up)); // see R11
  end

  // ========================================================================
  // Latch reset sources
  // ========================================================================
  // The remote input is a level; clear only when something is latched.
  always_comb begin
    hold_cnt_d = hold_cnt_q;
    btn_fired_d = btn_fired_q;
    if (!i_button) begin
      hold_cnt_d = 32'h0000_0000;
      btn_fired_d = 1'b0;
    end else if (hold_cnt_q < HOLD_CYC - 32'h0000_0001) begin
      hold_cnt_d = hold_cnt_q + 32'h0000_0001;
    end else begin
      btn_fired_d = 1'b1; // see R7
    end
    clear_req = (rpin_s2_q || (btn_fired_d && !btn_fired_q)) &&
                latched_q; // see R7 see R15
  end

  // ========================================================================
  // Alarm decision
  // ========================================================================
  always_comb begin
    alarm_d = alarm_q;
    latched_d = latched_q;
    if (i_flow_valid) begin
      unique case (mode)
        fao_pkg::FAO_MODE_SINGLE: begin
          unique case (latch_sel)
            fao_pkg::FAO_LATCH_HIGH: begin
              if (over) latched_d = 1'b1; // see R3
            end
            fao_pkg::FAO_LATCH_LOW: begin
              if (below) latched_d = 1'b1; // see R4
            end
            default: begin
              // Hysteresis only holds off the return to idle.
              if (above) alarm_d = 1'b1; // see R2
              else if (back_lo) alarm_d = 1'b0; // see R5
            end
          endcase
        end
        fao_pkg::FAO_MODE_DUAL: begin
          if (latch_sel != fao_pkg::FAO_LATCH_NONE) begin
            if (outside) latched_d = 1'b1; // see R11
          end else if (outside) begin
            alarm_d = 1'b1; // see R10
          end else if (back_in) begin
            alarm_d = 1'b0; // see R11
          end
        end
        fao_pkg::FAO_MODE_REVERSE: begin
          alarm_d = i_flow[31]; // see R12
          latched_d = 1'b0; // see R12
        end
        default: begin
          alarm_d = 1'b0;
          latched_d = 1'b0;
        end
      endcase
    end
    if (clear_req) latched_d = 1'b0; // see R6 see R15
    if (latched_d) alarm_d = 1'b1; // see R6
    if ((mode == fao_pkg::FAO_MODE_SINGLE ||
         mode == fao_pkg::FAO_MODE_DUAL) &&
        latch_sel != fao_pkg::FAO_LATCH_NONE && !latched_d)
      alarm_d = 1'b0; // see R1
    // A low latch sets on low flow, so its pin is on below threshold.
    if (mode == fao_pkg::FAO_MODE_OFF) out_d = 1'b0;
    else out_d = alarm_d ^ invert; // see R4 see R9
  end

  // ========================================================================
  // AXI4-Lite slave
  // ========================================================================
  // Address and data are taken in either order; response follows both.
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (i_awvalid && !aw_hold_q && !bvalid_q) begin
      aw_hold_d = 1'b1;
      awaddr_d = i_awaddr;
    end
    if (i_wvalid && !w_hold_q && !bvalid_q) begin
      w_hold_d = 1'b1;
      wdata_d = i_wdata;
      wstrb_d = i_wstrb;
    end
    do_write = aw_hold_q && w_hold_q && !bvalid_q;
    if (do_write) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      unique case (awaddr_q)
        `FAO_ADDR_CTRL, `FAO_ADDR_THR, `FAO_ADDR_UPPER, `FAO_ADDR_HYST,
        `FAO_ADDR_STAT, `FAO_ADDR_IRQ_ST, `FAO_ADDR_IRQ_MASK:
          bresp_d = `FAO_RESP_OKAY;
        default: bresp_d = `FAO_RESP_SLVERR;
      endcase
    end else if (bvalid_q && i_bready) begin
      bvalid_d = 1'b0;
    end
    if (i_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = `FAO_RESP_OKAY;
      unique case (i_araddr)
        `FAO_ADDR_CTRL: rdata_d = ctrl_q;
        `FAO_ADDR_THR: rdata_d = thr_q;
        `FAO_ADDR_UPPER: rdata_d = upper_q;
        `FAO_ADDR_HYST: rdata_d = {24'h00_0000, hyst_q};
        `FAO_ADDR_STAT: rdata_d = {29'h0000_0000, out_q, latched_q, alarm_q};
        `FAO_ADDR_IRQ_ST: rdata_d = {29'h0000_0000, ist_q};
        `FAO_ADDR_IRQ_MASK: rdata_d = {29'h0000_0000, imask_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = `FAO_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && i_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Byte-lane merge of a write into a 32-bit register.
  function automatic logic [31:0] fao_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  logic [31:0] hyst_m, ist_m, imask_m;
  always_comb begin
    ctrl_d = ctrl_q;
    thr_d = thr_q;
    upper_d = upper_q;
    hyst_d = hyst_q;
    imask_d = imask_q;
    hyst_m = fao_merge({24'h00_0000, hyst_q}, wdata_q, wstrb_q);
    imask_m = fao_merge({29'h0000_0000, imask_q}, wdata_q, wstrb_q);
    ist_m = fao_merge(32'h0000_0000, wdata_q, wstrb_q);
    ist_d = ist_q;
    if (do_write) begin
      unique case (awaddr_q)
        `FAO_ADDR_CTRL: ctrl_d = fao_merge(ctrl_q, wdata_q, wstrb_q);
        `FAO_ADDR_THR: thr_d = fao_merge(thr_q, wdata_q, wstrb_q);
        `FAO_ADDR_UPPER: upper_d = fao_merge(upper_q, wdata_q, wstrb_q);
        `FAO_ADDR_HYST: hyst_d = hyst_m[`FAO_HYST_W-1:0];
        `FAO_ADDR_IRQ_ST: ist_d = ist_q & ~ist_m[`FAO_IRQ_W-1:0];
        `FAO_ADDR_IRQ_MASK: imask_d = imask_m[`FAO_IRQ_W-1:0];
        default: ;
      endcase
    end
    // Events set after the clear so a coincident event is not lost.
    if (alarm_d && !alarm_q) ist_d[`FAO_IRQ_SET] = 1'b1;
    if (latched_d && !latched_q) ist_d[`FAO_IRQ_LATCH] = 1'b1;
    if (alarm_q && !alarm_d) ist_d[`FAO_IRQ_CLEAR] = 1'b1;
  end

  // ========================================================================
  // Registers
  // ========================================================================
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= `FAO_CTRL_RST;
      thr_q <= `FAO_THR_RST;
      upper_q <= `FAO_THR_RST;
      hyst_q <= `FAO_HYST_RST;
      ist_q <= '0;
      imask_q <= '0;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `FAO_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `FAO_RESP_OKAY;
      alarm_q <= 1'b0;
      latched_q <= 1'b0;
      out_q <= 1'b0;
      rpin_s1_q <= 1'b0;
      rpin_s2_q <= 1'b0;
      hold_cnt_q <= 32'h0000_0000;
      btn_fired_q <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      thr_q <= thr_d;
      upper_q <= upper_d;
      hyst_q <= hyst_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      alarm_q <= alarm_d;
      latched_q <= latched_d;
      out_q <= out_d;
      rpin_s1_q <= i_reset_pin; // see R15
      rpin_s2_q <= rpin_s1_q;
      hold_cnt_q <= hold_cnt_d;
      btn_fired_q <= btn_fired_d;
      o_irq <= |(ist_d & imask_d);
    end
  end

  assign o_alarm = out_q;
  assign o_latch_ind = latched_q; // see R6
  assign o_awready = aw_hold_q;
  assign o_wready = w_hold_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_arready = rvalid_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;

endmodule // fao_alarm

/* File: testbench/fao_alarm_asserts.sv */
// Port-level checker for the flow alarm output logic.
module fao_alarm_checker #(
  parameter logic [31:0] HOLD_CYC = 32'h0000_0014
) (
  input wire logic i_clk, // clock
  input wire logic i_rst, // async reset, high
  input wire logic i_reset_pin, // remote latch reset
  input wire logic i_button, // left button
  input wire logic i_arvalid, // read address valid
  input wire logic i_bready, // write response ready
  input wire logic i_rready, // read data ready
  input wire logic o_latch_ind, // latch indication
  input wire logic o_irq, // interrupt
  input wire logic o_awready, // write address ready
  input wire logic o_wready, // write data ready
  input wire logic o_bvalid, // write response valid
  input wire logic o_arready, // read address ready
  input wire logic [31:0] o_rdata, // read data
  input wire logic [1:0] o_rresp, // read response
  input wire logic o_rvalid // read data valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] held_d;
  logic [31:0] held_q;
  logic [3:0] pin_d;
  logic [3:0] pin_q;

  // ==========================================================
  // History
  // The latch may only drop once the synchroniser has seen the pin or the button has been held long enough.
  always_comb begin
    held_d = i_button ? held_q + 32'h1 : 32'h0;
    pin_d = {pin_q[2:0], i_reset_pin};
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      held_q <= 32'h0;
      pin_q <= 4'h0;
    end else begin
      held_q <= held_d;
      pin_q <= pin_d;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_bvalid_stands: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("bvalid dropped early");
  a_rvalid_stands: assert property (o_rvalid && !i_rready
    |=> o_rvalid && $stable(o_rdata)) else $error("read data not held");
  a_arready_match: assert property (o_arready == o_rvalid)
    else $error("arready differs from rvalid");
  a_awready_pulse: assert property (o_awready |=> !o_awready)
    else $error("awready longer than one cycle");
  a_write_answer: assert property (o_awready && o_wready |=> o_bvalid)
    else $error("write response late");
  a_read_answer: assert property (i_arvalid && !o_rvalid |=> o_rvalid)
    else $error("read response late");
  a_refused_zero: assert property (o_rvalid && o_rresp == 2'h2
    |-> o_rdata == 32'h0) else $error("refused read data not zero");
  a_latch_hold: assert property (
    o_latch_ind && !i_reset_pin && pin_q == 4'h0
    && held_q < HOLD_CYC - 32'h2 |=> o_latch_ind)
    else $error("latch dropped without a reset");
  a_remote_clear: assert property (
    $rose(i_reset_pin) && o_latch_ind |-> ##[1:5] !o_latch_ind)
    else $error("remote reset did not clear");
  a_button_clear: assert property (
    held_q == HOLD_CYC + 32'h3 |-> !o_latch_ind)
    else $error("button hold did not clear");

  c_latched: cover property ($rose(o_latch_ind));
  c_button: cover property (held_q == HOLD_CYC);
  c_irq: cover property ($rose(o_irq));
  c_refused: cover property (o_rvalid && o_rresp == 2'h2);
endmodule // fao_alarm_checker

/* File: testbench/fao_far_end.sv */
// Far-side model: remote reset input and front-panel button.
module fao_far_end (
  input wire logic i_clk, // bench clock
  output logic o_reset_pin, // remote latch reset level
  output logic o_button // left button, high while held
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_reset_pin = 1'b0;
    o_button = 1'b0;
  end
  // The level is held well past the two-flop synchroniser.
  task automatic remote_reset();
    @(posedge i_clk);
    o_reset_pin <= 1'b1;
    repeat (5) @(posedge i_clk);
    o_reset_pin <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic press(input int n);
    @(posedge i_clk);
    o_button <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_button <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
endmodule // fao_far_end

/* File: testbench/testbench.sv */
// Self-checking bench for the flow alarm output logic.
`include "fao_defines.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] HOLD = 32'h0000_0014;
  localparam logic [1:0] OK = `FAO_RESP_OKAY;
  logic i_clk, i_rst, fvalid, alarm, latch, irq, rpin, btn;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic signed [31:0] flow;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int fail_count, checks;
  int dual_f[6] = '{150, 250, 150, 50, 100, 200};
  logic dual_e[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  always #4 i_clk = ~i_clk;

  fao_alarm #(.HOLD_CYC(HOLD)) fao_alarm_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_flow(flow), .i_flow_valid(fvalid),
    .i_reset_pin(rpin), .i_button(btn), .o_alarm(alarm),
    .o_latch_ind(latch), .o_irq(irq), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready));
  fao_far_end fao_far_end_i (.i_clk(i_clk), .o_reset_pin(rpin),
    .o_button(btn));

  // ==========================================================
  // Checks and bus tasks
  task automatic tally_and_finish();
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge i_clk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        done = 1'b1;
      end
    end
    if (!done)
      chk("write timeout", 32'h1, 32'h0);
    if (!done)
      tally_and_finish();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge i_clk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rready <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        done = 1'b1;
      end
    end
    if (!done)
      chk("read timeout", 32'h1, 32'h0);
    if (!done)
      tally_and_finish();
  endtask
  // One flow sample, then the pin and the latch indication.
  task automatic step(input int f, input logic ea, input logic el);
    @(posedge i_clk);
    flow <= f;
    fvalid <= 1'b1;
    @(posedge i_clk);
    fvalid <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk("alarm", {31'h0, ea}, {31'h0, alarm});
    chk("latch", {31'h0, el}, {31'h0, latch});
  endtask

  // ==========================================================
  // Sequence
  initial begin
    {i_clk, fvalid, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    i_rst = 1'b1;
    flow = '0;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(`FAO_ADDR_CTRL, 32'h0, OK);
    rd(`FAO_ADDR_THR, 32'h0, OK);
    rd(`FAO_ADDR_HYST, 32'h0, OK);
    rd(`FAO_ADDR_STAT, 32'h0, OK);
    rd(8'h1C, 32'h0, `FAO_RESP_SLVERR);
    wr(8'h1C, 32'hFFFF_FFFF, `FAO_RESP_SLVERR);
    wr(`FAO_ADDR_THR, 32'h0000_0064, OK);
    wr(`FAO_ADDR_HYST, 32'h0000_000A, OK);
    wr(`FAO_ADDR_IRQ_MASK, 32'h0000_0001, OK);
    wr(`FAO_ADDR_CTRL, 32'h0000_0001, OK);
    step(99, 1'b0, 1'b0);
    step(100, 1'b1, 1'b0);
    chk("irq", 32'h1, {31'h0, irq});
    fao_far_end_i.remote_reset();
    step(90, 1'b1, 1'b0);
    step(89, 1'b0, 1'b0);
    rd(`FAO_ADDR_IRQ_ST, 32'h0000_0005, OK);
    wr(`FAO_ADDR_IRQ_ST, 32'h0000_0001, OK);
    rd(`FAO_ADDR_IRQ_ST, 32'h0000_0004, OK);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`FAO_ADDR_CTRL, 32'h0000_0011, OK);
    step(200, 1'b0, 1'b0);
    @(posedge i_clk);
    flow <= 50;
    repeat (4) @(posedge i_clk);
    chk("alarm", 32'h0, {31'h0, alarm});
    step(50, 1'b1, 1'b0);
    wr(`FAO_ADDR_CTRL, 32'h0000_0005, OK);
    step(100, 1'b0, 1'b0);
    step(150, 1'b1, 1'b1);
    rd(`FAO_ADDR_STAT, 32'h0000_0007, OK);
    step(0, 1'b1, 1'b1);
    fao_far_end_i.remote_reset();
    step(0, 1'b0, 1'b0);
    step(150, 1'b1, 1'b1);
    fao_far_end_i.press(10);
    step(0, 1'b1, 1'b1);
    fao_far_end_i.press(30);
    step(0, 1'b0, 1'b0);
    wr(`FAO_ADDR_CTRL, 32'h0000_0009, OK);
    step(150, 1'b0, 1'b0);
    step(50, 1'b1, 1'b1);
    step(150, 1'b1, 1'b1);
    fao_far_end_i.remote_reset();
    step(150, 1'b0, 1'b0);
    wr(`FAO_ADDR_HYST, 32'h0, OK);
    wr(`FAO_ADDR_UPPER, 32'h0000_00C8, OK);
    wr(`FAO_ADDR_CTRL, 32'h0000_0002, OK);
    for (int k = 0; k < 6; k++) begin
      step(dual_f[k], dual_e[k], 1'b0);
    end
    wr(`FAO_ADDR_HYST, 32'h0000_000A, OK);
    step(201, 1'b1, 1'b0);
    step(190, 1'b1, 1'b0);
    step(150, 1'b0, 1'b0);
    wr(`FAO_ADDR_CTRL, 32'h0000_0006, OK);
    step(250, 1'b1, 1'b1);
    step(150, 1'b1, 1'b1);
    fao_far_end_i.remote_reset();
    step(150, 1'b0, 1'b0);
    wr(`FAO_ADDR_CTRL, 32'h0000_0003, OK);
    step(-5, 1'b1, 1'b0);
    step(5, 1'b0, 1'b0);
    wr(`FAO_ADDR_CTRL, 32'h0000_0013, OK);
    step(-5, 1'b0, 1'b0);
    wr(`FAO_ADDR_CTRL, 32'h0000_0007, OK);
    step(-5, 1'b1, 1'b0);
    step(5, 1'b0, 1'b0);
    tally_and_finish();
  end
endmodule // testbench

bind fao_alarm fao_alarm_checker #(.HOLD_CYC(HOLD_CYC)) fao_alarm_checker_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_reset_pin(i_reset_pin),
  .i_button(i_button), .i_arvalid(i_arvalid), .i_bready(i_bready),
  .i_rready(i_rready), .o_latch_ind(o_latch_ind), .o_irq(o_irq),
  .o_awready(o_awready), .o_wready(o_wready), .o_bvalid(o_bvalid),
  .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
  .o_rvalid(o_rvalid));
